// ==== rtl/iqp_pkg.sv ====
// constants, field positions and helpers shared by both ends of the parallel I/Q port
// assumes a 10 MHz system clock at each end and one control word driven by local logic
//
// Function
// - rate bit halves word clock, parallel quadrature only
// - format bit: twos complement or offset binary
// - clock enable clear holds word clock pin low
// - word clock high marks Q at full rate, invert swaps
// - transmit gate polarity follows its invert bit
// - pairing bit picks I first or Q first
// - inactive gate without hold drives zeros
// - inactive gate with hold keeps last value
// - single tone mode disregards hold setting
// - enabled validation latches possible violation on pin
// - validation disable resets check, pin low, default
// - reset: clock enabled, validation disabled, other controls cleared
// - serial select turns pins to serial plus GPIO
package iqp_pkg;

	// ----------------------------------------------------------------
	// second control function register fields
	// ----------------------------------------------------------------
	localparam int SERIAL_SEL_BIT = 31;
	localparam int RATE_BIT = 13;
	localparam int FORMAT_BIT = 12;
	localparam int CLK_EN_BIT = 11;
	localparam int CLK_INV_BIT = 10;
	localparam int GATE_INV_BIT = 9;
	localparam int Q_FIRST_BIT = 8;
	localparam int HOLD_BIT = 6;
	localparam int VAL_DIS_BIT = 5;
	// clock enable and validation disable set, everything else clear
	localparam logic [31:0] SECOND_CONTROL_FUNCTION_REGISTER_RESET = 32'h0000_0820;

	// ----------------------------------------------------------------
	// operating mode field of the first control function register
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_QUADRATURE = 2'h0;
	localparam logic [1:0] MODE_SINGLE_TONE = 2'h1;

	// ----------------------------------------------------------------
	// data word and pin mapping
	// ----------------------------------------------------------------
	localparam int WORD_W = 18;
	localparam int GPIO_W = 16;
	localparam int SERIAL_LO = 4;
	localparam int SERIAL_HI = 5;

	// ----------------------------------------------------------------
	// timing: one word slot on the link
	// ----------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int SLOT_NS = 1600;
	localparam int SLOT_CYC = SLOT_NS / CLK_NS; // longest time, rounds down
	// pin register, three sampling flops each way and the source register
	localparam int MIN_SLOT_CYC = 12;

	// offset binary and twos complement differ only in the sign bit
	function automatic logic [WORD_W-1:0] fmtConvert(input logic [WORD_W-1:0] w,
		input logic offsetBin);
		fmtConvert = offsetBin ? {~w[WORD_W-1], w[WORD_W-2:0]} : w;
	endfunction

endpackage

// ==== rtl/iqp_if.sv ====
// pins between the upconverter parallel port and the baseband data source
// assumes the testbench instances it and hands each modport to one end
`timescale 1ns/1ps
interface iqp_if;
	logic parallelWordClockPin;
	logic [iqp_pkg::WORD_W-1:0] dataBus;
	logic transmitGateInput;
	logic syncSampleErrorPin;

	modport device (
		output parallelWordClockPin,
		output syncSampleErrorPin,
		input dataBus,
		input transmitGateInput
	);

	modport source (
		input parallelWordClockPin,
		input syncSampleErrorPin,
		output dataBus,
		output transmitGateInput
	);
endinterface

// ==== rtl/iqp_source_end.sv ====
// baseband data source: follows the word clock and presents I/Q words
// assumes cfgWord matches the device's control word and SLOT_CYCLES matches its slot
`timescale 1ns/1ps
module iqp_source_end #(
	parameter int SLOT_CYCLES = iqp_pkg::SLOT_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	iqp_if.source link,
	input wire logic [31:0] cfgWord,
	input wire logic [1:0] opMode,
	input wire logic sendEnable,
	input wire logic [iqp_pkg::WORD_W-1:0] pairI,
	input wire logic [iqp_pkg::WORD_W-1:0] pairQ,
	input wire logic pairValid,
	output logic pairReady,
	output logic syncErrSeen
);
	logic clkS1_r, clkS2_r, clkS3_r, clkVal_r;
	logic [iqp_pkg::WORD_W-1:0] pendI_r, pendQ_r;
	logic [iqp_pkg::WORD_W-1:0] secondWord_r;
	logic [15:0] waitCnt_r;
	logic secondDue_r;
	logic clkNxt, edgeSeen, halfRate, isQ, firstIsQ, takePair;
	logic [iqp_pkg::WORD_W-1:0] firstWord;

	// elaboration checks: link latency and the width of the second-word counter
	if (SLOT_CYCLES < iqp_pkg::MIN_SLOT_CYC) begin
		$error("slot too short for link latency");
	end
	if (SLOT_CYCLES > 2 ** $bits(waitCnt_r)) begin
		$error("slot too long for the wait counter");
	end

	// ----------------------------------------------------------------
	// word clock sampling, a change counts when stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clkS1_r <= 1'b0;
			clkS2_r <= 1'b0;
			clkS3_r <= 1'b0;
			clkVal_r <= 1'b0;
		end else begin
			clkS1_r <= link.parallelWordClockPin;
			clkS2_r <= clkS1_r;
			clkS3_r <= clkS2_r;
			clkVal_r <= clkNxt;
		end
	end

	// decode of the edge and of which word it calls for
	always_comb begin
		clkNxt = (clkS2_r == clkS3_r) ? clkS3_r : clkVal_r;
		edgeSeen = clkNxt != clkVal_r;
		halfRate = cfgWord[iqp_pkg::RATE_BIT] && !cfgWord[iqp_pkg::SERIAL_SEL_BIT]
			&& opMode == iqp_pkg::MODE_QUADRATURE;
		firstIsQ = cfgWord[iqp_pkg::Q_FIRST_BIT];
		isQ = clkNxt ^ cfgWord[iqp_pkg::CLK_INV_BIT];
		takePair = edgeSeen && (halfRate || isQ == firstIsQ);
		firstWord = firstIsQ ? (pairValid ? pairQ : pendQ_r) : (pairValid ? pairI : pendI_r);
	end

	// ----------------------------------------------------------------
	// pair fetch: a new pair is taken at each first-word slot where pairValid is high
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pendI_r <= '0;
			pendQ_r <= '0;
			pairReady <= 1'b0;
		end else begin
			pairReady <= takePair && pairValid;
			if (takePair && pairValid) begin
				pendI_r <= pairI;
				pendQ_r <= pairQ;
			end
		end
	end

	// ----------------------------------------------------------------
	// data pins; an empty user side repeats the last pair
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link.dataBus <= '0;
			secondWord_r <= '0;
			secondDue_r <= 1'b0;
			waitCnt_r <= '0;
		end else begin
			if (takePair) begin
				link.dataBus <= iqp_pkg::fmtConvert(firstWord,
					cfgWord[iqp_pkg::FORMAT_BIT]);
				secondWord_r <= firstIsQ ? (pairValid ? pairI : pendI_r)
					: (pairValid ? pairQ : pendQ_r);
				secondDue_r <= halfRate;
				waitCnt_r <= 16'(SLOT_CYCLES - 1);
			end else if (edgeSeen) begin
				link.dataBus <= iqp_pkg::fmtConvert(secondWord_r,
					cfgWord[iqp_pkg::FORMAT_BIT]);
				secondDue_r <= 1'b0;
			end else if (secondDue_r) begin
				// half rate: second word one slot after the edge
				if (waitCnt_r == '0) begin
					link.dataBus <= iqp_pkg::fmtConvert(secondWord_r,
						cfgWord[iqp_pkg::FORMAT_BIT]);
					secondDue_r <= 1'b0;
				end else begin
					waitCnt_r <= waitCnt_r - 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit gate and error pin observation
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link.transmitGateInput <= 1'b0;
			syncErrSeen <= 1'b0;
		end else begin
			link.transmitGateInput <= sendEnable ^ cfgWord[iqp_pkg::GATE_INV_BIT];
			syncErrSeen <= link.syncSampleErrorPin;
		end
	end
endmodule

// ==== rtl/iqp_device_end.sv ====
// upconverter parallel port: word clock generation, data assembler and timing check
// assumes cfgWord and opMode come from the control registers on this clock
`timescale 1ns/1ps
module iqp_device_end #(
	parameter int SLOT_CYCLES = iqp_pkg::SLOT_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	iqp_if.device link,
	input wire logic [31:0] cfgWord,
	input wire logic [1:0] opMode,
	output logic [iqp_pkg::WORD_W-1:0] basebandI,
	output logic [iqp_pkg::WORD_W-1:0] basebandQ,
	output logic basebandValid,
	output logic [iqp_pkg::GPIO_W-1:0] gpioIn,
	output logic [1:0] serialIn
);
	logic [31:0] cfg_r;
	logic [1:0] mode_r;
	logic [15:0] slotCnt_r;
	logic slotOdd_r;
	logic wordClk_r;
	logic [iqp_pkg::WORD_W-1:0] dS1_r, dS2_r, dS3_r, dVal_r;
	logic gS1_r, gS2_r, gS3_r, gVal_r;
	logic [iqp_pkg::WORD_W-1:0] firstWord_r;
	logic haveFirst_r;
	logic syncErr_r;
	logic slotEnd, halfRate, serialSel, capture, wordIsQ, firstIsQ, isFirst, gateActive;
	logic holdOn;
	logic [iqp_pkg::WORD_W-1:0] dNxt, wordIn;
	logic gNxt;

	// elaboration checks: the pipeline needs the slot length, the counter bounds it
	if (SLOT_CYCLES < iqp_pkg::MIN_SLOT_CYC) begin
		$error("slot too short for link latency");
	end
	if (SLOT_CYCLES > 2 ** $bits(slotCnt_r)) begin
		$error("slot too long for the slot counter");
	end

	// ----------------------------------------------------------------
	// control word capture
	// ----------------------------------------------------------------
	// registered so every control has a defined value out of reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= iqp_pkg::SECOND_CONTROL_FUNCTION_REGISTER_RESET;
			mode_r <= iqp_pkg::MODE_QUADRATURE;
		end else begin
			cfg_r <= cfgWord;
			mode_r <= opMode;
		end
	end

	// decoded controls
	always_comb begin
		serialSel = cfg_r[iqp_pkg::SERIAL_SEL_BIT];
		halfRate = cfg_r[iqp_pkg::RATE_BIT] && !serialSel
			&& mode_r == iqp_pkg::MODE_QUADRATURE;
		firstIsQ = cfg_r[iqp_pkg::Q_FIRST_BIT];
		// single tone ignores the hold bit, so zeros are forced
		holdOn = cfg_r[iqp_pkg::HOLD_BIT] && mode_r != iqp_pkg::MODE_SINGLE_TONE;
		slotEnd = slotCnt_r == 16'(SLOT_CYCLES - 1);
		capture = slotEnd;
	end

	// ----------------------------------------------------------------
	// word clock: internal clock always runs, the pin may be gated
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slotCnt_r <= '0;
			slotOdd_r <= 1'b0;
			wordClk_r <= 1'b0;
		end else begin
			slotCnt_r <= slotEnd ? 16'h0000 : slotCnt_r + 16'h0001;
			if (slotEnd) begin
				slotOdd_r <= ~slotOdd_r;
				// half rate toggles once per pair, full rate once per word
				if (!halfRate || slotOdd_r) begin
					wordClk_r <= ~wordClk_r;
				end
			end
		end
	end

	// pin copy; the internal clock keeps timing the assembler when gated
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link.parallelWordClockPin <= 1'b0;
		end else begin
			link.parallelWordClockPin <= cfg_r[iqp_pkg::CLK_EN_BIT] & wordClk_r;
		end
	end

	// ----------------------------------------------------------------
	// pin sampling, a change counts when stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dS1_r <= '0;
			dS2_r <= '0;
			dS3_r <= '0;
			dVal_r <= '0;
			gS1_r <= 1'b0;
			gS2_r <= 1'b0;
			gS3_r <= 1'b0;
			gVal_r <= 1'b0;
		end else begin
			dS1_r <= link.dataBus;
			dS2_r <= dS1_r;
			dS3_r <= dS2_r;
			dVal_r <= dNxt;
			gS1_r <= link.transmitGateInput;
			gS2_r <= gS1_r;
			gS3_r <= gS2_r;
			gVal_r <= gNxt;
		end
	end

	// word type, gate sense and format decode
	always_comb begin
		dNxt = (dS2_r == dS3_r) ? dS3_r : dVal_r;
		gNxt = (gS2_r == gS3_r) ? gS3_r : gVal_r;
		gateActive = (gVal_r ^ cfg_r[iqp_pkg::GATE_INV_BIT]) && !serialSel;
		if (halfRate) begin
			isFirst = !slotOdd_r;
			wordIsQ = isFirst ? firstIsQ : !firstIsQ;
		end else begin
			wordIsQ = wordClk_r ^ cfg_r[iqp_pkg::CLK_INV_BIT];
			isFirst = wordIsQ == firstIsQ;
		end
		wordIn = iqp_pkg::fmtConvert(dVal_r, cfg_r[iqp_pkg::FORMAT_BIT]);
	end

	// ----------------------------------------------------------------
	// data assembler: pairs words, forces zeros or holds when gated off
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			firstWord_r <= '0;
			haveFirst_r <= 1'b0;
			basebandI <= '0;
			basebandQ <= '0;
			basebandValid <= 1'b0;
		end else begin
			basebandValid <= 1'b0;
			if (capture) begin
				basebandValid <= !isFirst;
				if (!gateActive) begin
					haveFirst_r <= 1'b0;
					if (!holdOn) begin
						basebandI <= '0;
						basebandQ <= '0;
					end
				end else if (isFirst) begin
					firstWord_r <= wordIn;
					haveFirst_r <= 1'b1;
				end else if (haveFirst_r) begin
					// a second word without its first is dropped
					basebandI <= wordIsQ ? firstWord_r : wordIn;
					basebandQ <= wordIsQ ? wordIn : firstWord_r;
					haveFirst_r <= 1'b0;
				end
			end
		end
	end
	// holding needs no action: the outputs keep their last pair

	// ----------------------------------------------------------------
	// setup/hold check: data moving at the capture instant is suspect
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			syncErr_r <= 1'b0;
		end else if (cfg_r[iqp_pkg::VAL_DIS_BIT]) begin
			syncErr_r <= 1'b0;
		end else if (capture && !serialSel && dS2_r != dS3_r) begin
			syncErr_r <= 1'b1;
		end
	end

	// error pin straight from its latch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link.syncSampleErrorPin <= 1'b0;
		end else begin
			link.syncSampleErrorPin <= syncErr_r;
		end
	end

	// ----------------------------------------------------------------
	// serial select: two pins to serial input, the rest to GPIO
	// ----------------------------------------------------------------
	// only the pin remap is done here; the serial deframer lives elsewhere
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gpioIn <= '0;
			serialIn <= '0;
		end else if (serialSel) begin
			gpioIn <= {dVal_r[iqp_pkg::WORD_W-1:iqp_pkg::SERIAL_HI+1],
				dVal_r[iqp_pkg::SERIAL_LO-1:0]};
			serialIn <= dVal_r[iqp_pkg::SERIAL_HI:iqp_pkg::SERIAL_LO];
		end else begin
			gpioIn <= '0;
			serialIn <= '0;
		end
	end
endmodule

// ==== verification/iqp_properties.sv ====
// link pin assertions for the parallel I/Q port
// assumes both ends share clk and resetn
`timescale 1ns/1ps
module iqp_properties #(
	parameter int SLOT_CYCLES = 12
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic parallelWordClockPin,
	input wire logic [iqp_pkg::WORD_W-1:0] dataBus,
	input wire logic transmitGateInput,
	input wire logic syncSampleErrorPin
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic [7:0] highRun_r;
	logic [7:0] sinceEdge_r;
	// -------------------------
	// helper counters
	// -------------------------
	// saturate so a stopped word clock cannot wrap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			highRun_r <= 8'h00;
		end else if (!parallelWordClockPin) begin
			highRun_r <= 8'h00;
		end else if (highRun_r != 8'hff) begin
			highRun_r <= highRun_r + 8'h01;
		end
	end
	// cycles since the last word clock edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sinceEdge_r <= 8'h00;
		end else if ($changed(parallelWordClockPin)) begin
			sinceEdge_r <= 8'h00;
		end else if (sinceEdge_r != 8'hff) begin
			sinceEdge_r <= sinceEdge_r + 8'h01;
		end
	end
	// -------------------------
	// properties
	// -------------------------
	property p_clkSlot;
		$changed(parallelWordClockPin) |=> $stable(parallelWordClockPin) [*8];
	endproperty
	property p_clkMax;
		highRun_r <= 8'(2 * SLOT_CYCLES);
	endproperty
	property p_quietStart;
		$rose(resetn) |-> (parallelWordClockPin == 1'b0) [*8];
	endproperty
	property p_dataReset;
		$rose(resetn) |-> dataBus == 18'h00000 && syncSampleErrorPin == 1'b0;
	endproperty
	property p_dataHold;
		$changed(dataBus) |=> $stable(dataBus) [*8];
	endproperty
	property p_dataLag;
		$changed(dataBus) |-> $stable(parallelWordClockPin) && sinceEdge_r >= 8'h02;
	endproperty
	property p_gateHold;
		$changed(transmitGateInput) |=> $stable(transmitGateInput) [*2];
	endproperty
	property p_noErr;
		syncSampleErrorPin == 1'b0;
	endproperty
	a_clkSlot: assert property (p_clkSlot) else $error("word clock slot too short");
	a_clkMax: assert property (p_clkMax) else $error("word clock high too long");
	a_quietStart: assert property (p_quietStart) else $error("early word clock");
	a_dataReset: assert property (p_dataReset) else $error("pins not idle");
	a_dataHold: assert property (p_dataHold) else $error("word not held");
	a_dataLag: assert property (p_dataLag) else $error("word moved at edge");
	a_gateHold: assert property (p_gateHold) else $error("gate glitch");
	a_noErr: assert property (p_noErr) else $error("error pin on clean link");
	c_clkRise: cover property ($rose(parallelWordClockPin));
	c_dataMove: cover property ($changed(dataBus));
	c_gateFall: cover property ($fell(transmitGateInput));
endmodule

// ==== verification/iq_parallel_port_config_tb.sv ====
// bench: device and source ends on one link, a device end fed by the bench on a second
// assumes both ends of a link see the same control word
`timescale 1ns/1ps
module iq_parallel_port_config_tb;
	localparam int SLOT = 12;
	localparam logic [31:0] BASE = iqp_pkg::SECOND_CONTROL_FUNCTION_REGISTER_RESET;
	logic clk;
	logic resetn;
	logic [31:0] cfg;
	logic [31:0] cfg2;
	logic [1:0] mode;
	logic sendEn;
	logic pValid;
	logic toggleOn;
	logic [17:0] pI;
	logic [17:0] pQ;
	logic [17:0] d2;
	logic [17:0] bI;
	logic [17:0] bQ;
	logic bValid;
	logic pRdy;
	logic errSeen;
	logic [15:0] gpio2;
	logic [1:0] ser2;
	int failures;
	int checkCount;
	int cycles;
	int bitList[5] = '{iqp_pkg::Q_FIRST_BIT, iqp_pkg::GATE_INV_BIT, iqp_pkg::CLK_INV_BIT,
		iqp_pkg::FORMAT_BIT, iqp_pkg::RATE_BIT};
	iqp_if i_iqp_if();
	iqp_if i_iqp_if_b();
	// second link: the bench plays a source that breaks timing on purpose
	assign i_iqp_if_b.dataBus = d2;
	assign i_iqp_if_b.transmitGateInput = 1'b1;
	iqp_device_end #(.SLOT_CYCLES(SLOT)) i_iqp_device_end (.clk(clk), .resetn(resetn),
		.link(i_iqp_if.device), .cfgWord(cfg), .opMode(mode), .basebandI(bI),
		.basebandQ(bQ), .basebandValid(bValid), .gpioIn(), .serialIn());
	iqp_source_end #(.SLOT_CYCLES(SLOT)) i_iqp_source_end (.clk(clk), .resetn(resetn),
		.link(i_iqp_if.source), .cfgWord(cfg), .opMode(mode), .sendEnable(sendEn),
		.pairI(pI), .pairQ(pQ), .pairValid(pValid), .pairReady(pRdy), .syncErrSeen(errSeen));
	iqp_device_end #(.SLOT_CYCLES(SLOT)) i_iqp_device_end_b (.clk(clk), .resetn(resetn),
		.link(i_iqp_if_b.device), .cfgWord(cfg2), .opMode(2'h0), .basebandI(),
		.basebandQ(), .basebandValid(), .gpioIn(gpio2), .serialIn(ser2));
	iqp_properties #(.SLOT_CYCLES(SLOT)) i_iqp_properties (.clk(clk), .resetn(resetn),
		.parallelWordClockPin(i_iqp_if.parallelWordClockPin), .dataBus(i_iqp_if.dataBus),
		.transmitGateInput(i_iqp_if.transmitGateInput),
		.syncSampleErrorPin(i_iqp_if.syncSampleErrorPin));
	// -------------------------
	// clock, timeout, helpers
	// -------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// data that moves every cycle must trip the timing check
	always @(negedge clk) begin
		if (toggleOn) d2 <= ~d2;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// control word is only taken cleanly after a reset, so each case on the first link restarts
	task automatic restart(input logic [31:0] c, input logic [1:0] m);
		@(negedge clk);
		cfg = c;
		mode = m;
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
	endtask
	task automatic waitValid(input int n);
		int k;
		k = 0;
		while (n > 0 && k < 400) begin
			@(posedge clk);
			#1;
			if (bValid === 1'b1) n--;
			k++;
		end
		check(n, 0);
	endtask
	// -------------------------
	// scenarios
	// -------------------------
	task automatic t_xfer(input logic [31:0] c);
		logic [17:0] w;
		int n;
		int k;
		restart(c, iqp_pkg::MODE_QUADRATURE);
		sendEn = 1'b1;
		pValid = 1'b1;
		pI = pI + 18'h00111;
		pQ = pQ - 18'h00123;
		waitValid(3);
		check(bI, pI);
		check(bQ, pQ);
		check(i_iqp_if.transmitGateInput, c[9] ? 1'b0 : 1'b1);
		check(errSeen, 1'b0);
		// the source must take a fresh pair within four slots, twice the pair slot
		k = 0;
		while (pRdy !== 1'b1 && k < 4 * SLOT) begin
			@(posedge clk);
			#1;
			k++;
		end
		check(pRdy, 1'b1);
		w = c[10] ? pI : pQ;
		w[17] = w[17] ^ c[12];
		@(posedge i_iqp_if.parallelWordClockPin);
		n = 0;
		while (i_iqp_if.parallelWordClockPin === 1'b1 && n < 99) begin
			@(posedge clk);
			#1;
			n++;
			if (n == 8 && !c[13]) check(i_iqp_if.dataBus, w);
		end
		check(n, c[13] ? 2 * SLOT : SLOT);
	endtask
	task automatic t_gate(input logic hold, input logic [1:0] m);
		logic [17:0] keepI;
		restart(BASE | (32'(hold) << iqp_pkg::HOLD_BIT), m);
		sendEn = 1'b1;
		waitValid(3);
		@(negedge clk);
		keepI = pI;
		sendEn = 1'b0;
		pI = ~pI;
		waitValid(4);
		check(bI, (hold && m != iqp_pkg::MODE_SINGLE_TONE) ? keepI : 18'h00000);
	endtask
	task automatic t_clkOff();
		int hi;
		restart(BASE & ~(32'h1 << iqp_pkg::CLK_EN_BIT), iqp_pkg::MODE_QUADRATURE);
		hi = 0;
		repeat (60) begin
			@(posedge clk);
			#1;
			if (i_iqp_if.parallelWordClockPin !== 1'b0) hi++;
		end
		check(hi, 0);
		waitValid(2); // assembler keeps its timing while the pin sits low
	endtask
	task automatic t_errCheck();
		toggleOn = 1'b1;
		repeat (40) @(negedge clk);
		check(i_iqp_if_b.syncSampleErrorPin, 1'b0);
		cfg2 = BASE & ~(32'h1 << iqp_pkg::VAL_DIS_BIT);
		repeat (40) @(negedge clk);
		check(i_iqp_if_b.syncSampleErrorPin, 1'b1);
		toggleOn = 1'b0;
		repeat (40) @(negedge clk);
		check(i_iqp_if_b.syncSampleErrorPin, 1'b1);
		cfg2 = BASE;
		repeat (4) @(negedge clk);
		check(i_iqp_if_b.syncSampleErrorPin, 1'b0);
	endtask
	task automatic t_serial();
		cfg2 = BASE | (32'h1 << iqp_pkg::SERIAL_SEL_BIT);
		d2 = 18'h2a5c3;
		repeat (5) @(negedge clk);
		check(gpio2, {d2[17:6], d2[3:0]});
		check(ser2, d2[5:4]);
	endtask
	task automatic end_sim();
		if (failures == 0 && checkCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		resetn = 1'b0;
		cfg = BASE;
		cfg2 = BASE;
		mode = 2'h0;
		sendEn = 1'b0;
		pValid = 1'b0;
		toggleOn = 1'b0;
		pI = 18'h20005;
		pQ = 18'h1fff0;
		d2 = 18'h00000;
		t_xfer(BASE);
		foreach (bitList[i]) t_xfer(BASE | (32'h1 << bitList[i]));
		// timing check armed on a clean link: the error pin must stay low
		t_xfer(BASE & ~(32'h1 << iqp_pkg::VAL_DIS_BIT));
		t_gate(1'b0, iqp_pkg::MODE_QUADRATURE);
		t_gate(1'b1, iqp_pkg::MODE_QUADRATURE);
		t_gate(1'b1, iqp_pkg::MODE_SINGLE_TONE);
		t_clkOff();
		t_errCheck();
		t_serial();
		end_sim();
	end
endmodule
